/* File: rtl/slim_reg_pkg.sv */
/*
 Shared constants, message layouts and message builders for the control
 register bridge carried over a simplified serial message link.
 Assumes both ends run on the same nominal core clock rate.
*/
package slim_reg_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int LA_W = 8;
	localparam int MSG_W = 56;
	localparam logic [5:0] MSG_LEN_BITS = 6'h38;

	// ****************************************************************
	// message field values
	// ****************************************************************
	localparam logic [7:0] MGR_LA = 8'hFF;
	localparam logic ACCESS_BYTE = 1'h1;
	localparam logic [2:0] SLICE_2BYTE = 3'h1;
	localparam logic [11:0] PAGE_ADDR = 12'h800;
	localparam logic [11:0] DATA_BASE = 12'hA00;
	localparam logic [11:0] DATA_LAST = 12'hBFE;
	localparam logic [15:0] PAGE_RESET = 16'h0000;
	// message codes: values are arbitrary local encodings
	localparam logic [7:0] MSG_CHANGE_VALUE = 8'h01;
	localparam logic [7:0] MSG_REQUEST_VALUE = 8'h02;
	localparam logic [7:0] MSG_REPLY_VALUE = 8'h03;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int LINK_PERIOD_NS = 800;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [7:0] REPLY_TIMEOUT_BITS = 8'hC8;

	// ****************************************************************
	// message layouts, sent most significant bit first
	// ****************************************************************
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] src;
		logic [7:0] dst;
		logic accMode;
		logic [2:0] slice;
		logic [11:0] byteAddr;
		logic [15:0] value;
	} req_msg_s;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] src;
		logic [7:0] dst;
		logic [15:0] tid;
		logic [15:0] data;
	} reply_msg_s;

	// value map byte address of one data element
	function automatic logic [11:0] data_addr(input logic [7:0] low);
		return DATA_BASE + {3'h0, low, 1'h0};
	endfunction : data_addr

	// manager-sourced request in byte mode with a two-byte slice
	function automatic logic [MSG_W-1:0] make_request(input logic [7:0] code,
		input logic [7:0] dst, input logic [11:0] ba, input logic [15:0] val);
		req_msg_s m;
		m.code = code;
		m.src = MGR_LA;
		m.dst = dst;
		m.accMode = ACCESS_BYTE;
		m.slice = SLICE_2BYTE;
		m.byteAddr = ba;
		m.value = val;
		return m;
	endfunction : make_request

endpackage : slim_reg_pkg

/* File: rtl/slim_link_if.sv */
/*
 Link wires between the manager end and the device end.
 Assumes the manager makes the link clock; the bench joins both ends here.
*/
`timescale 1ns/1ps
`default_nettype none

interface slim_link_if;
	logic linkClk;
	logic mgrFrame;
	logic mgrData;
	logic devFrame;
	logic devData;

	modport manager (output linkClk, output mgrFrame, output mgrData,
		input devFrame, input devData);
	modport device (input linkClk, input mgrFrame, input mgrData,
		output devFrame, output devData);
endinterface : slim_link_if

`default_nettype wire

/* File: rtl/slim_reg_device.sv */
/*
 Device end: decodes value-map messages from the manager into accesses of
 the internal control register space and answers reads with replies.
 Assumes the link clock is far slower than clk, and that the register
 space returns read data in the cycle after the read pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module slim_reg_device
(
	slim_link_if.device link, // serial link to the manager
	input wire logic clk, // core clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic [slim_reg_pkg::LA_W-1:0] myLa, // assigned logical address
	output logic regWrite, // one-cycle write strobe
	output logic regRead, // one-cycle read strobe
	output logic [slim_reg_pkg::ADDR_W-1:0] regAddr, // control register address
	output logic [slim_reg_pkg::DATA_W-1:0] regWdata, // write data
	input wire logic [slim_reg_pkg::DATA_W-1:0] regRdata // read data, cycle after read
);
	import slim_reg_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [1:0] clkSync;
		logic clkPrev;
		logic [1:0] frmSync;
		logic [1:0] datSync;
		logic frmPrev;
		logic [MSG_W-1:0] rxShift;
		logic [5:0] rxCount;
		logic [15:0] page;
		logic [ADDR_W-1:0] regAddr;
		logic [DATA_W-1:0] regWdata;
		logic regWrite;
		logic regRead;
		logic rdCapture;
		logic [15:0] tid;
		logic [MSG_W-1:0] txShift;
		logic [5:0] txCount;
		logic txGap;
		logic devFrame;
		logic devData;
	} dev_state_s;

	dev_state_s s_reg;
	dev_state_s s_next;

	// ****************************************************************
	// next state
	// ****************************************************************
	// one process holds the whole behaviour so every flop has one driver
	always_comb
	begin
		logic rise;
		logic fall;
		logic accepted;
		logic isData;
		logic [7:0] low;
		req_msg_s m;
		reply_msg_s r;
		rise = 1'h0;
		fall = 1'h0;
		accepted = 1'h0;
		isData = 1'h0;
		low = 8'h00;
		m = req_msg_s'(s_reg.rxShift);
		r = '0;
		s_next = s_reg;
		s_next.regWrite = 1'h0;
		s_next.regRead = 1'h0;
		s_next.rdCapture = s_reg.regRead;

		// all link inputs share one two-stage path so they stay aligned
		s_next.clkSync = {s_reg.clkSync[0], link.linkClk};
		s_next.frmSync = {s_reg.frmSync[0], link.mgrFrame};
		s_next.datSync = {s_reg.datSync[0], link.mgrData};
		s_next.clkPrev = s_reg.clkSync[1];
		rise = s_reg.clkSync[1] & ~s_reg.clkPrev;
		fall = ~s_reg.clkSync[1] & s_reg.clkPrev;

		// receive on rising link edges; frame drop marks message end
		if (rise)
		begin
			s_next.frmPrev = s_reg.frmSync[1];
			if (s_reg.frmSync[1])
			begin
				s_next.rxShift = {s_reg.rxShift[MSG_W-2:0], s_reg.datSync[1]};
				if (s_reg.rxCount != 6'h3F)
				begin
					s_next.rxCount = 6'(s_reg.rxCount + 6'h01);
				end
			end
			else
			begin
				s_next.rxCount = 6'h00;
				// short or long frames are dropped whole
				if (s_reg.frmPrev && s_reg.rxCount == MSG_LEN_BITS)
				begin
					accepted = (m.src == MGR_LA)
						&& (m.dst == myLa)
						&& (m.accMode == ACCESS_BYTE)
						&& (m.slice == SLICE_2BYTE);
				end
			end
		end

		// data element window: even addresses from the base only
		isData = (m.byteAddr >= DATA_BASE) && (m.byteAddr <= DATA_LAST)
			&& !m.byteAddr[0];
		low = 8'((m.byteAddr - DATA_BASE) >> 1);

		if (accepted)
		begin
			if (m.code == MSG_CHANGE_VALUE && m.byteAddr == PAGE_ADDR)
			begin
				// page kept until the next page message
				s_next.page = m.value;
			end
			else if (m.code == MSG_CHANGE_VALUE && isData)
			begin
				s_next.regAddr = {s_reg.page, low};
				s_next.regWdata = m.value;
				s_next.regWrite = 1'h1;
			end
			else if (m.code == MSG_REQUEST_VALUE && isData)
			begin
				s_next.regAddr = {s_reg.page, low};
				s_next.tid = m.value;
				s_next.regRead = 1'h1;
			end
		end

		// transmit on falling link edges, a low bit time between frames
		if (fall)
		begin
			if (s_reg.txGap || s_reg.txCount == 6'h00)
			begin
				s_next.devFrame = 1'h0;
				s_next.devData = 1'h0;
				s_next.txGap = 1'h0;
			end
			else
			begin
				s_next.devFrame = 1'h1;
				s_next.devData = s_reg.txShift[MSG_W-1];
				s_next.txShift = {s_reg.txShift[MSG_W-2:0], 1'h0};
				s_next.txCount = 6'(s_reg.txCount - 6'h01);
			end
		end

		// read data in: build the reply, restarting any reply in flight
		if (s_reg.rdCapture)
		begin
			r.code = MSG_REPLY_VALUE;
			r.src = myLa;
			r.dst = MGR_LA;
			r.tid = s_reg.tid;
			r.data = regRdata;
			s_next.txShift = r;
			s_next.txCount = MSG_LEN_BITS;
			// older reply is abandoned, a gap tells the manager so
			s_next.txGap = s_reg.devFrame | fall;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// reset leaves the page at its reset value and the link idle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_reg <= '0;
			s_reg.page <= PAGE_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// outputs, all straight from flops
	// ****************************************************************
	assign regWrite = s_reg.regWrite;
	assign regRead = s_reg.regRead;
	assign regAddr = s_reg.regAddr;
	assign regWdata = s_reg.regWdata;
	assign link.devFrame = s_reg.devFrame;
	assign link.devData = s_reg.devData;

endmodule : slim_reg_device

`default_nettype wire

/* File: rtl/slim_reg_manager.sv */
/*
 Manager end: turns register commands into page and data messages, makes
 the link clock by dividing clk, and collects read replies.
 Assumes one command at a time through a valid/ready handshake.
*/
`timescale 1ns/1ps
`default_nettype none

module slim_reg_manager
(
	slim_link_if.manager link, // serial link to the device
	input wire logic clk, // core clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic [slim_reg_pkg::LA_W-1:0] destLa, // device logical address
	input wire logic cmdValid, // command offered
	input wire logic cmdRead, // 1 read, 0 write
	input wire logic [slim_reg_pkg::ADDR_W-1:0] cmdAddr, // register address
	input wire logic [slim_reg_pkg::DATA_W-1:0] cmdWdata, // write data
	input wire logic [15:0] cmdTid, // transaction id for reads
	output logic cmdReady, // command can be taken
	output logic rspValid, // one-cycle reply pulse
	output logic rspTimeout, // one-cycle pulse, no reply came
	output logic [15:0] rspTid, // reply transaction id
	output logic [slim_reg_pkg::DATA_W-1:0] rspData // reply data
);
	import slim_reg_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_PAGE = 2'b01,
		M_CMD = 2'b10,
		M_WAIT = 2'b11
	} mgr_state_e;

	typedef struct packed {
		mgr_state_e state;
		logic [2:0] divCnt;
		logic linkClk;
		logic [1:0] frmSync;
		logic [1:0] datSync;
		logic frmPrev;
		logic [MSG_W-1:0] rxShift;
		logic [5:0] rxCount;
		logic [MSG_W-1:0] txShift;
		logic [5:0] txCount;
		logic mgrFrame;
		logic mgrData;
		logic [15:0] page;
		logic pageValid;
		logic isRead;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [15:0] tid;
		logic [7:0] waitCnt;
		logic cmdReady;
		logic rspValid;
		logic rspTimeout;
		logic [15:0] rspTid;
		logic [DATA_W-1:0] rspData;
	} mgr_state_s;

	mgr_state_s s_reg;
	mgr_state_s s_next;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		logic fall;
		logic done;
		logic [7:0] code;
		reply_msg_s r;
		fall = 1'h0;
		done = 1'h0;
		code = MSG_CHANGE_VALUE;
		r = reply_msg_s'(s_reg.rxShift);
		s_next = s_reg;
		s_next.rspValid = 1'h0;
		s_next.rspTimeout = 1'h0;

		// divider: the link clock is ours, so its edges need no detection
		if (s_reg.divCnt == 3'(LINK_HALF_CYC - 1))
		begin
			s_next.divCnt = 3'h0;
			s_next.linkClk = ~s_reg.linkClk;
			fall = s_reg.linkClk;
		end
		else
		begin
			s_next.divCnt = 3'(s_reg.divCnt + 3'h1);
		end

		// reply lines cross in through two flops each
		s_next.frmSync = {s_reg.frmSync[0], link.devFrame};
		s_next.datSync = {s_reg.datSync[0], link.devData};

		// sample replies and shift requests out on falling edges
		if (fall)
		begin
			s_next.frmPrev = s_reg.frmSync[1];
			if (s_reg.frmSync[1])
			begin
				s_next.rxShift = {s_reg.rxShift[MSG_W-2:0], s_reg.datSync[1]};
				if (s_reg.rxCount != 6'h3F)
				begin
					s_next.rxCount = 6'(s_reg.rxCount + 6'h01);
				end
			end
			else
			begin
				s_next.rxCount = 6'h00;
				done = s_reg.frmPrev && s_reg.rxCount == MSG_LEN_BITS;
			end
			if (s_reg.txCount == 6'h00)
			begin
				s_next.mgrFrame = 1'h0;
				s_next.mgrData = 1'h0;
			end
			else
			begin
				s_next.mgrFrame = 1'h1;
				s_next.mgrData = s_reg.txShift[MSG_W-1];
				s_next.txShift = {s_reg.txShift[MSG_W-2:0], 1'h0};
				s_next.txCount = 6'(s_reg.txCount - 6'h01);
			end
		end

		code = s_reg.isRead ? MSG_REQUEST_VALUE : MSG_CHANGE_VALUE;
		unique case (s_reg.state)
			M_IDLE:
			begin
				// ready comes up once after reset; nothing can be taken before it
				if (!s_reg.pageValid && !s_reg.cmdReady)
				begin
					s_next.cmdReady = 1'h1;
				end
				else if (cmdValid && s_reg.cmdReady)
				begin
					s_next.cmdReady = 1'h0;
					s_next.isRead = cmdRead;
					s_next.addr = cmdAddr;
					s_next.wdata = cmdWdata;
					s_next.tid = cmdTid;
					s_next.txCount = MSG_LEN_BITS;
					if (!s_reg.pageValid || cmdAddr[23:8] != s_reg.page)
					begin
						s_next.page = cmdAddr[23:8];
						s_next.pageValid = 1'h1;
						s_next.txShift = make_request(MSG_CHANGE_VALUE, destLa,
							PAGE_ADDR, cmdAddr[23:8]);
						s_next.state = M_PAGE;
					end
					else
					begin
						// unchanged page: the page message is skipped
						s_next.txShift = make_request(cmdRead ? MSG_REQUEST_VALUE
							: MSG_CHANGE_VALUE, destLa, data_addr(cmdAddr[7:0]),
							cmdRead ? cmdTid : cmdWdata);
						s_next.state = M_CMD;
					end
				end
			end
			M_PAGE:
			begin
				if (s_reg.txCount == 6'h00 && !s_reg.mgrFrame)
				begin
					s_next.txShift = make_request(code, destLa, data_addr(s_reg.addr[7:0]),
						s_reg.isRead ? s_reg.tid : s_reg.wdata);
					s_next.txCount = MSG_LEN_BITS;
					s_next.state = M_CMD;
				end
			end
			M_CMD:
			begin
				if (s_reg.txCount == 6'h00 && !s_reg.mgrFrame)
				begin
					s_next.waitCnt = 8'h00;
					s_next.state = s_reg.isRead ? M_WAIT : M_IDLE;
					s_next.cmdReady = !s_reg.isRead;
				end
			end
			M_WAIT:
			begin
				// no new request until the reply or the timeout
				if (done && r.code == MSG_REPLY_VALUE && r.src == destLa
					&& r.dst == MGR_LA && r.tid == s_reg.tid)
				begin
					s_next.rspValid = 1'h1;
					s_next.rspTid = r.tid;
					s_next.rspData = r.data;
					s_next.cmdReady = 1'h1;
					s_next.state = M_IDLE;
				end
				else if (fall && s_reg.waitCnt == REPLY_TIMEOUT_BITS)
				begin
					s_next.rspTimeout = 1'h1;
					s_next.cmdReady = 1'h1;
					s_next.state = M_IDLE;
				end
				else if (fall)
				begin
					s_next.waitCnt = 8'(s_reg.waitCnt + 8'h01);
				end
			end
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// reset leaves the link idle and the command port closed
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// outputs, all straight from flops
	// ****************************************************************
	assign cmdReady = s_reg.cmdReady;
	assign rspValid = s_reg.rspValid;
	assign rspTimeout = s_reg.rspTimeout;
	assign rspTid = s_reg.rspTid;
	assign rspData = s_reg.rspData;
	assign link.linkClk = s_reg.linkClk;
	assign link.mgrFrame = s_reg.mgrFrame;
	assign link.mgrData = s_reg.mgrData;

endmodule : slim_reg_manager

`default_nettype wire

/* File: tb/slim_link_asserts.sv */
/*
 Wire checks on the link that joins the manager end to the device end.
 Assumes the manager makes linkClk from clk, so clk sees every link edge.
*/
`timescale 1ns/1ps
`default_nettype none

module slim_link_asserts
(
	input wire logic clk, // core clock
	input wire logic resetn, // reset, active low
	input wire logic linkClk, // link clock
	input wire logic mgrFrame, // manager frame
	input wire logic mgrData, // manager bit
	input wire logic devFrame, // device frame
	input wire logic devData // device bit
);
	import slim_reg_pkg::*;

	typedef struct packed {
		logic linkPrev;
		logic framePrev;
		logic [9:0] frmCnt;
		logic [55:0] mShift;
		logic [55:0] dShift;
		logic [15:0] lastVal;
	} chk_s;

	chk_s st_reg;
	chk_s st_next;
	logic rise;
	logic [11:0] ba;

	// ****************************************************************
	// helper: rebuild both messages from the wire
	// ****************************************************************
	assign rise = linkClk && !st_reg.linkPrev;
	assign ba = st_reg.mShift[27:16];
	// bits are taken at link rise, half a bit after the manager launched them; device bits one clk after launch
	always_comb
	begin
		st_next = st_reg;
		st_next.linkPrev = linkClk;
		st_next.framePrev = mgrFrame;
		st_next.frmCnt = mgrFrame ? st_reg.frmCnt + 10'h001 : 10'h000;
		if (rise && mgrFrame)
			st_next.mShift = {st_reg.mShift[54:0], mgrData};
		if (rise && devFrame)
			st_next.dShift = {st_reg.dShift[54:0], devData};
		if (st_reg.framePrev && !mgrFrame && st_reg.mShift[55:48] == MSG_REQUEST_VALUE)
			st_next.lastVal = st_reg.mShift[15:0];
	end
	// helper state register
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;

	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_mgrEnd;
		$fell(mgrFrame);
	endsequence
	sequence s_reqEnd;
		$fell(mgrFrame) ##0 st_reg.mShift[55:48] == MSG_REQUEST_VALUE;
	endsequence
	sequence s_devEnd;
		$fell(devFrame);
	endsequence
	property p_srcMgr;
		s_mgrEnd |-> st_reg.mShift[47:40] == MGR_LA;
	endproperty
	a_srcMgr: assert property (p_srcMgr) else $error("bad message source");
	property p_modeSlice;
		s_mgrEnd |-> st_reg.mShift[31:28] == {ACCESS_BYTE, SLICE_2BYTE};
	endproperty
	a_modeSlice: assert property (p_modeSlice) else $error("bad mode or slice");
	property p_addrMap;
		s_mgrEnd |-> ba == PAGE_ADDR || (!ba[0] && ba >= DATA_BASE && ba <= DATA_LAST);
	endproperty
	a_addrMap: assert property (p_addrMap) else $error("bad element address");
	property p_pageIsChange;
		s_mgrEnd ##0 ba == PAGE_ADDR |-> st_reg.mShift[55:48] == MSG_CHANGE_VALUE;
	endproperty
	a_pageIsChange: assert property (p_pageIsChange) else $error("page not a change");
	property p_frameLen;
		s_mgrEnd |-> st_reg.frmCnt == 10'h1C0;
	endproperty
	a_frameLen: assert property (p_frameLen) else $error("frame length wrong");
	property p_replyFollows;
		s_reqEnd |-> ##[1:40] $rose(devFrame);
	endproperty
	a_replyFollows: assert property (p_replyFollows) else $error("no reply started");
	property p_replyHead;
		s_devEnd |-> st_reg.dShift[55:48] == MSG_REPLY_VALUE && st_reg.dShift[39:32] == MGR_LA;
	endproperty
	a_replyHead: assert property (p_replyHead) else $error("bad reply header");
	property p_tidEcho;
		s_devEnd |-> st_reg.dShift[31:16] == st_reg.lastVal;
	endproperty
	a_tidEcho: assert property (p_tidEcho) else $error("reply id differs");
	property p_oneAtATime;
		devFrame |-> !$rose(mgrFrame);
	endproperty
	a_oneAtATime: assert property (p_oneAtATime) else $error("frame during reply");
endmodule : slim_link_asserts

`default_nettype wire

/* File: tb/tb_slimbus_register_access_bridge.sv */
/*
 Bench: manager and device joined on one link, plus a second device fed
 by hand with broken and overlapping messages.
 Assumes the design package and link interface are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", nm, exp, got); end end

module tb_slimbus_register_access_bridge;
	import slim_reg_pkg::*;

	localparam logic [7:0] LA = 8'h21;
	localparam logic [7:0] LA2 = 8'h5A;
	localparam logic [3:0] MODE = {ACCESS_BYTE, SLICE_2BYTE};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cmdValid = 1'b0;
	logic cmdRead = 1'b0;
	logic [23:0] cmdAddr = 24'h000000;
	logic [15:0] cmdWdata = 16'h0000;
	logic [15:0] cmdTid = 16'h0000;
	logic [15:0] regRdata = 16'h0000;
	logic cmdReady, rspValid, rspTimeout, regWrite, regRead, reg2Write;
	logic [15:0] rspTid, rspData, regWdata, reg2Wdata, regRdata2;
	logic [23:0] regAddr, reg2Addr;
	logic [55:0] mShift, dShift, r2Shift;
	logic [55:0] mq[$];
	logic [55:0] rq[$];
	int wCnt = 0, w2Cnt = 0, toCnt = 0, bad_count = 0, n_tests = 0, cycles = 0;

	slim_link_if lnk();
	slim_link_if lnk2();
	slim_reg_manager slim_reg_manager_inst (.link(lnk), .clk(clk), .resetn(resetn), .destLa(LA),
		.cmdValid(cmdValid), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
		.cmdTid(cmdTid), .cmdReady(cmdReady), .rspValid(rspValid), .rspTimeout(rspTimeout),
		.rspTid(rspTid), .rspData(rspData));
	slim_reg_device slim_reg_device_inst (.link(lnk), .clk(clk), .resetn(resetn), .myLa(LA),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata));
	slim_reg_device slim_reg_device_fault_inst (.link(lnk2), .clk(clk), .resetn(resetn),
		.myLa(LA2), .regWrite(reg2Write), .regRead(), .regAddr(reg2Addr),
		.regWdata(reg2Wdata), .regRdata(regRdata2));
	slim_link_asserts slim_link_asserts_inst (.clk(clk), .resetn(resetn), .linkClk(lnk.linkClk),
		.mgrFrame(lnk.mgrFrame), .mgrData(lnk.mgrData), .devFrame(lnk.devFrame),
		.devData(lnk.devData));

	// ****************************************************************
	// clock, register space model, monitors
	// ****************************************************************
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	assign regRdata2 = ~reg2Addr[15:0];
	// read data lands the cycle after the strobe; a hang ends the run as a failure
	always @(posedge clk)
	begin
		if (regRead)
			regRdata <= regAddr[15:0] ^ 16'h5A3C;
		if (regWrite)
			wCnt <= wCnt + 1;
		if (reg2Write)
			w2Cnt <= w2Cnt + 1;
		if (rspTimeout)
			toCnt <= toCnt + 1;
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	// whole messages off the wire, read at link rise
	always @(posedge lnk.linkClk)
	begin
		if (lnk.mgrFrame)
			mShift = {mShift[54:0], lnk.mgrData};
		if (lnk.devFrame)
			dShift = {dShift[54:0], lnk.devData};
	end
	always @(negedge lnk.mgrFrame)
		mq.push_back(mShift);
	always @(negedge lnk.devFrame)
		rq.push_back(dShift);

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// one manager command; judges wire messages, strobes and reply
	task automatic runOp(input logic rd, input logic [23:0] a, input logic [15:0] d,
		input logic [15:0] t, input logic newPage);
		int k;
		int w0;
		logic [55:0] pageMsg;
		logic [55:0] dataMsg;
		logic [55:0] replyMsg;
		pageMsg = {MSG_CHANGE_VALUE, MGR_LA, LA, MODE, PAGE_ADDR, a[23:8]};
		dataMsg = {rd ? MSG_REQUEST_VALUE : MSG_CHANGE_VALUE, MGR_LA, LA, MODE,
			DATA_BASE + {3'h0, a[7:0], 1'h0}, rd ? t : d};
		replyMsg = {MSG_REPLY_VALUE, LA, MGR_LA, t, a[15:0] ^ 16'h5A3C};
		mq.delete();
		rq.delete();
		w0 = wCnt;
		k = 0;
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdRead <= rd;
		cmdAddr <= a;
		cmdWdata <= d;
		cmdTid <= t;
		do
			@(negedge clk);
		while (cmdReady !== 1'b1 && k++ < 100);
		@(posedge clk);
		cmdValid <= 1'b0;
		k = 0;
		do
			@(negedge clk);
		while ((rd ? rspValid : cmdReady) !== 1'b1 && k++ < 4000);
		k = 0;
		while (!rd && wCnt == w0 && k++ < 60)
			@(negedge clk);
		`CHECK("message count", newPage ? 2 : 1, mq.size())
		if (newPage)
			`CHECK("page message", pageMsg, mq[0])
		`CHECK("data message", dataMsg, mq[mq.size() - 1])
		`CHECK("register address", a, regAddr)
		if (rd)
		begin
			`CHECK("reply id", t, rspTid)
			`CHECK("reply data", replyMsg[15:0], rspData)
			`CHECK("reply message", replyMsg, rq[0])
			`CHECK("timeout count", 0, toCnt)
		end
		else
		begin
			`CHECK("write count", w0 + 1, wCnt)
			`CHECK("write data", d, regWdata)
		end
	endtask : runOp

	// hand-made link traffic for the second device; the clock runs only through each frame and its tail bits
	task automatic sendRaw(input logic [55:0] m, input int tail);
		int i;
		for (i = 55; i >= -tail; i--)
		begin
			// bit and frame change with the link fall, eight clk per bit
			@(posedge clk);
			lnk2.linkClk <= 1'b0;
			lnk2.mgrFrame <= (i >= 0);
			lnk2.mgrData <= (i >= 0) ? m[i] : ~m[0];
			repeat (4) @(posedge clk);
			lnk2.linkClk <= 1'b1;
			// reply bit launched after the last fall is settled by now
			@(negedge clk);
			if (lnk2.devFrame === 1'b1)
				r2Shift = {r2Shift[54:0], lnk2.devData};
			repeat (3) @(posedge clk);
		end
		// park the clock low between frames
		@(posedge clk);
		lnk2.linkClk <= 1'b0;
	endtask : sendRaw

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_writeFreshPage();
		runOp(1'b0, 24'h123456, 16'hBEEF, 16'h0000, 1'b1);
	endtask : t_writeFreshPage

	task automatic t_writeTopLowSamePage();
		runOp(1'b0, 24'h1234FF, 16'h0001, 16'h0000, 1'b0);
	endtask : t_writeTopLowSamePage

	task automatic t_readNewPage();
		runOp(1'b1, 24'h00AB00, 16'h0000, 16'hC0DE, 1'b1);
	endtask : t_readNewPage

	task automatic t_readThenWriteSamePage();
		runOp(1'b1, 24'h00AB01, 16'h0000, 16'hFFFF, 1'b0);
		runOp(1'b0, 24'h00AB7F, 16'h8001, 16'h0000, 1'b0);
	endtask : t_readThenWriteSamePage

	// broken messages leave no strobe and no page; newest request wins the reply
	task automatic t_refuseAndReplace();
		logic [55:0] bad [7];
		int j;
		int w0;
		bad[0] = {MSG_CHANGE_VALUE, 8'hFE, LA2, MODE, 12'hA10, 16'h1111};
		bad[1] = {MSG_CHANGE_VALUE, MGR_LA, 8'h5B, MODE, 12'hA10, 16'h1111};
		bad[2] = {MSG_CHANGE_VALUE, MGR_LA, LA2, 4'h1, 12'hA10, 16'h1111};
		bad[3] = {MSG_CHANGE_VALUE, MGR_LA, LA2, 4'hA, 12'hA10, 16'h1111};
		bad[4] = {MSG_CHANGE_VALUE, MGR_LA, LA2, MODE, 12'hA11, 16'h1111};
		bad[5] = {MSG_CHANGE_VALUE, MGR_LA, LA2, MODE, 12'hC00, 16'h1111};
		bad[6] = {MSG_CHANGE_VALUE, 8'hFE, LA2, MODE, PAGE_ADDR, 16'h9999};
		sendRaw({MSG_CHANGE_VALUE, MGR_LA, LA2, MODE, PAGE_ADDR, 16'h0077}, 3);
		w0 = w2Cnt;
		for (j = 0; j < 7; j++)
			sendRaw(bad[j], 3);
		`CHECK("broken messages ignored", w0, w2Cnt)
		sendRaw({MSG_CHANGE_VALUE, MGR_LA, LA2, MODE, 12'hA10, 16'h2222}, 3);
		`CHECK("accepted write count", w0 + 1, w2Cnt)
		`CHECK("accepted write address", 24'h007708, reg2Addr)
		`CHECK("accepted write data", 16'h2222, reg2Wdata)
		sendRaw({MSG_REQUEST_VALUE, MGR_LA, LA2, MODE, 12'hA02, 16'h0001}, 3);
		sendRaw({MSG_REQUEST_VALUE, MGR_LA, LA2, MODE, 12'hA06, 16'h0002}, 70);
		`CHECK("newest reply", {MSG_REPLY_VALUE, LA2, MGR_LA, 16'h0002, 16'h88FC}, r2Shift)
	endtask : t_refuseAndReplace

	// main sequence
	initial
	begin
		lnk2.linkClk = 1'b0;
		lnk2.mgrFrame = 1'b0;
		lnk2.mgrData = 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		t_writeFreshPage();
		t_writeTopLowSamePage();
		t_readNewPage();
		t_readThenWriteSamePage();
		t_refuseAndReplace();
		end_of_test();
	end
endmodule : tb_slimbus_register_access_bridge

`default_nettype wire
